// ==== verilog/pms_sequencer.sv ====
// Overview of operation
// - power-up enables rails one step at a time in rank order 13,6,4,2,3,5,7,1,12,11,10,8,9.
// - with power hold and main power request both high every rail is on.
// - power hold high and main request low is sleep, keeping only rails 1,6,7,12,13 on.
// - both controls low with the backup supply good leaves only rail 13 on.
// - both controls low with the backup supply low turns every rail off including rail 13.
// - power hold and main request are plain levels that directly pick the rail set.
// - the push-button is an enable request through a resistor and a reset request when direct.
// - a manual reset press is only seen through the decoded direct-press flag.
// - a timer measures how long a manual reset press lasts and picks the action from it.
// - a press under 4 s pulls reset low at once until release plus the reset timeout.
// - a press over 4 s turns all rails off and, if power hold is high at release, sequences them back on.
// - if power hold is not high when the button is released after an enable press, all go off.
`timescale 1ns/100ps
module pms_sequencer
    import pms_pkg::*;
#(
    parameter int unsigned LONG_PRESS = LONG_PRESS_CYC,
    parameter int unsigned RST_TIMEOUT = RST_TIMEOUT_CYC,
    // spacing between rail steps; a short value keeps a bench ramp affordable
    parameter int unsigned STEP = STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic power_hold_in_i,
    input wire logic main_power_request_i,
    input wire logic pushbutton_in_n_i,
    input wire logic manual_reset_press_i,
    input wire logic backup_supply_sense_i,
    output logic [RAILS-1:0] rail_en_o,
    output logic rail_keepalive_o,
    output logic system_reset_out_n_o,
    output logic system_reset_out_n_oe_o,
    output logic pushbutton_status_n_o,
    output logic pushbutton_status_n_oe_o,
    output logic [5:0] state_o
);
    pms_sync_if sync_bus ();

    // raw button level is active low; flag is direct-path decode
    pms_input_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .raw_i({manual_reset_press_i, ~pushbutton_in_n_i,
            main_power_request_i, power_hold_in_i}),
        .sync(sync_bus.src)
    );

    wire hold = sync_bus.power_hold_in;
    wire req = sync_bus.main_power_request;
    wire pressed = sync_bus.pushbutton_pressed;
    // a direct press counts only while the button is actually down
    wire mr_press = sync_bus.manual_reset_press & pressed;
    wire enable_press = pressed & ~sync_bus.manual_reset_press;

    pms_state_e state;
    pms_state_e next_state;
    logic [RANK_W-1:0] rank;
    logic [RANK_W-1:0] next_rank;
    logic [RAILS-1:0] rails;
    logic [RAILS-1:0] next_rails;
    logic [CNT_W-1:0] step_cnt;
    logic [CNT_W-1:0] press_cnt;
    logic [CNT_W-1:0] rst_cnt;
    logic mr_active;
    logic long_done;
    logic reset_low;
    logic boot_wait;

    // only the rail of the current rank; a late target change never adds two at once
    logic [RAILS-1:0] ranked;
    genvar gi;
    generate
        for (gi = 0; gi < RAILS; gi++) begin : g_rank
            assign ranked[gi] = (pms_rank(gi) == rank);
        end
    endgenerate

    // level decode of the mode target, no latching of inputs
    wire [RAILS-1:0] mode_target = (hold & req) ? ALL_RAILS :
        hold ? SLEEP_ON_MASK :
        backup_supply_sense_i ? KEEPALIVE_MASK :
        {RAILS{1'b0}};
    wire step_tick = (step_cnt == CNT_W'(STEP - 1));
    wire press_long = (press_cnt >= CNT_W'(LONG_PRESS));
    wire rst_expired = (rst_cnt >= CNT_W'(RST_TIMEOUT));
    wire rank_last = (rank == LAST_RANK);
    wire want_on = hold | req;

    // step pacing; runs only while ramping
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt <= '0;
        end else if (ce_i) begin
            step_cnt <= (state == PMS_RAMP && !step_tick) ? step_cnt + 1'b1 : '0;
        end
    end

    // press timer: counts while a direct press is held
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            press_cnt <= '0;
            mr_active <= 1'b0;
            long_done <= 1'b0;
        end else if (ce_i) begin
            mr_active <= mr_press ? 1'b1 : (pressed ? mr_active : 1'b0);
            press_cnt <= mr_press ? (press_long ? press_cnt : press_cnt + 1'b1) : '0;
            long_done <= mr_press ? (long_done | press_long) : 1'b0;
        end
    end

    // reset output: low at boot and during a short press until release plus timeout
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_low <= 1'b1;
            rst_cnt <= '0;
        end else if (ce_i) begin
            if (mr_active || state != PMS_RUN) begin
                reset_low <= 1'b1;
                rst_cnt <= '0;
            end else if (rst_expired) begin
                reset_low <= 1'b0;
            end else begin
                rst_cnt <= rst_cnt + 1'b1;
            end
        end
    end

    // sequencing state machine
    always_comb begin
        next_state = state;
        next_rank = rank;
        next_rails = rails;
        case (state)
            PMS_OFF: begin
                next_rails = mode_target & KEEPALIVE_MASK;
                next_rank = FIRST_RANK;
                if (enable_press || want_on) begin
                    next_state = PMS_RAMP;
                end
            end
            PMS_RAMP: begin
                // only rails in the target (every rail while boot_wait) are brought up, in rank order
                next_rails = rails | (ranked & (boot_wait ? ALL_RAILS : mode_target));
                if (boot_wait && !pressed && !hold) begin
                    // button let go before the host took hold: abort the boot at once
                    next_state = PMS_OFF;
                    next_rails = {RAILS{1'b0}};
                end else if (!boot_wait && !want_on) begin
                    next_state = PMS_OFF;
                end else if (step_tick) begin
                    if (rank_last) begin
                        next_state = boot_wait ? PMS_BOOT : PMS_RUN;
                    end else begin
                        next_rank = rank + 1'b1;
                    end
                end
            end
            PMS_BOOT: begin
                // wait for the processor to take hold before release
                if (hold) begin
                    next_state = PMS_RUN;
                end else if (!pressed) begin
                    next_state = PMS_OFF;
                    next_rails = {RAILS{1'b0}};
                end
            end
            PMS_RUN: begin
                if (long_done) begin
                    next_state = PMS_CYCLE;
                end else if ((mode_target & ~rails) != '0) begin
                    next_state = PMS_RAMP;
                    next_rank = FIRST_RANK;
                end else begin
                    next_rails = mode_target;
                    if (!want_on) begin
                        next_state = PMS_OFF;
                    end
                end
            end
            PMS_CYCLE: begin
                next_rails = {RAILS{1'b0}};
                next_state = PMS_HOLD;
            end
            PMS_HOLD: begin
                // stay dark until the button is let go, then ramp back up if power hold is high
                next_rails = {RAILS{1'b0}};
                next_rank = FIRST_RANK;
                if (!pressed) begin
                    next_state = PMS_RAMP;
                end
            end
            default: begin
                next_state = PMS_OFF;
                next_rails = {RAILS{1'b0}};
            end
        endcase
    end

    // boot_wait marks a ramp started by an enable press with hold and req low, or by leaving the power-cycle hold
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= PMS_OFF;
            rank <= FIRST_RANK;
            rails <= {RAILS{1'b0}};
            boot_wait <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            rank <= next_rank;
            rails <= next_rails;
            if (state == PMS_OFF) begin
                boot_wait <= enable_press & ~want_on;
            end else if (state == PMS_HOLD) begin
                boot_wait <= 1'b1;
            end
        end
    end

    assign rail_en_o = rails;
    assign rail_keepalive_o = rails[RAILS-1];
    assign system_reset_out_n_o = 1'b0;
    assign system_reset_out_n_oe_o = ~reset_low; // low enable = driving low
    assign pushbutton_status_n_o = 1'b0;
    assign pushbutton_status_n_oe_o = ~pressed;
    assign state_o = state;
endmodule

// ==== verilog/pms_pkg.sv ====
package pms_pkg;
    localparam int unsigned RAILS = 13;
    localparam int unsigned RANK_W = 4;
    localparam int unsigned CLK_HZ = 40_000_000;
    // press length that splits soft reset from power cycle, in ms
    localparam int unsigned LONG_PRESS_MS = 4000;
    localparam int unsigned LONG_PRESS_CYC = CLK_HZ / 1000 * LONG_PRESS_MS;
    // reset timeout after release, in ms
    localparam int unsigned RST_TIMEOUT_MS = 64;
    localparam int unsigned RST_TIMEOUT_CYC = CLK_HZ / 1000 * RST_TIMEOUT_MS;
    // spacing between two rail steps, in us
    localparam int unsigned STEP_US = 100;
    localparam int unsigned STEP_CYC = CLK_HZ / 1000_000 * STEP_US;
    localparam int unsigned CNT_W = 28;
    // rail bit positions: bit n-1 is rail n
    localparam logic [RAILS-1:0] SLEEP_ON_MASK = 13'h1861; // rails 1,6,7,12,13
    localparam logic [RAILS-1:0] KEEPALIVE_MASK = 13'h1000; // rail 13
    localparam logic [RAILS-1:0] ALL_RAILS = 13'h1fff;
    localparam logic [RANK_W-1:0] LAST_RANK = 4'hc;
    localparam logic [RANK_W-1:0] FIRST_RANK = 4'h0;

    // rank of each rail, index = rail number - 1
    function automatic logic [RANK_W-1:0] pms_rank(input int unsigned idx);
        logic [RANK_W-1:0] r;
        r = 4'h0;
        case (idx)
            0: r = 4'h7;
            1: r = 4'h3;
            2: r = 4'h4;
            3: r = 4'h2;
            4: r = 4'h5;
            5: r = 4'h1;
            6: r = 4'h6;
            7: r = 4'hb;
            8: r = 4'hc;
            9: r = 4'ha;
            10: r = 4'h9;
            11: r = 4'h8;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    typedef enum logic [5:0] {
        PMS_OFF    = 6'h01,
        PMS_RAMP   = 6'h02,
        PMS_BOOT   = 6'h04,
        PMS_RUN    = 6'h08,
        PMS_CYCLE  = 6'h10,
        PMS_HOLD   = 6'h20
    } pms_state_e;
endpackage

// ==== verilog/pms_sync_if.sv ====
`timescale 1ns/100ps
interface pms_sync_if;
    logic power_hold_in;
    logic main_power_request;
    logic pushbutton_pressed;
    logic manual_reset_press;
    modport src (output power_hold_in, output main_power_request,
        output pushbutton_pressed, output manual_reset_press);
    modport dst (input power_hold_in, input main_power_request,
        input pushbutton_pressed, input manual_reset_press);
endinterface

// ==== verilog/pms_input_sync.sv ====
`timescale 1ns/100ps
module pms_input_sync
    import pms_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] raw_i,
    pms_sync_if.src sync
);
    logic [3:0] stage1;
    logic [3:0] stage2;

    // two flops per input; only stage2 is ever decoded
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= 4'h0;
            stage2 <= 4'h0;
        end else if (ce_i) begin
            stage1 <= raw_i;
            stage2 <= stage1;
        end
    end

    assign sync.power_hold_in = stage2[0];
    assign sync.main_power_request = stage2[1];
    assign sync.pushbutton_pressed = stage2[2];
    assign sync.manual_reset_press = stage2[3];
endmodule

// ==== sim/pms_sequencer_sva.sv ====
`timescale 1ns/100ps
module pms_sequencer_sva
    import pms_pkg::*;
#(
    parameter int unsigned LONG_PRESS = 200,
    parameter int unsigned RST_TIMEOUT = 20,
    parameter int unsigned STEP = 400
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic power_hold_in_i,
    input wire logic main_power_request_i,
    input wire logic pushbutton_in_n_i,
    input wire logic manual_reset_press_i,
    input wire logic backup_supply_sense_i,
    input wire logic [RAILS-1:0] rail_en_o,
    input wire logic rail_keepalive_o,
    input wire logic system_reset_out_n_oe_o,
    input wire logic [5:0] state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [RAILS-1:0] prev;
    logic [12:0] gap;
    wire [RAILS-1:0] up_w = rail_en_o & ~prev;
    wire lo_w = !power_hold_in_i && !main_power_request_i && pushbutton_in_n_i;
    // gap since the last rail came up; saturates so a long idle never wraps
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev <= '0;
            gap <= '1;
        end else begin
            prev <= rail_en_o;
            gap <= (up_w != '0) ? 13'h0 : gap + {12'h0, gap != 13'h1fff};
        end
    end
    chk_keepalive_copy: assert property (rail_keepalive_o == rail_en_o[12])
        else $error("keepalive differs from rail 13");
    chk_allon_rails: assert property ((power_hold_in_i && main_power_request_i &&
        state_o == 6'h08)[*4] |-> rail_en_o == ALL_RAILS) else $error("all-on rails wrong");
    chk_sleep_rails: assert property ((power_hold_in_i && !main_power_request_i &&
        state_o == 6'h08)[*6] |-> (rail_en_o & ~SLEEP_ON_MASK) == '0)
        else $error("sleep rails wrong");
    chk_shutdown_keep: assert property ((lo_w && backup_supply_sense_i)[*6]
        |-> (rail_en_o & ~KEEPALIVE_MASK) == '0) else $error("shutdown rails wrong");
    chk_all_off: assert property ((lo_w && !backup_supply_sense_i)[*6] |-> rail_en_o == '0)
        else $error("rails on with backup low");
    chk_one_step: assert property (up_w != '0 |-> $onehot(up_w))
        else $error("several rails rose together");
    chk_step_gap: assert property (up_w != '0 && state_o == 6'h02 &&
        $past(state_o) == 6'h02 |-> gap >= STEP - 1) else $error("rail step too soon");
    chk_press_reset: assert property ($rose(!pushbutton_in_n_i && manual_reset_press_i)
        |-> ##[1:4] !system_reset_out_n_oe_o) else $error("reset not driven on press");
    chk_reset_hold: assert property ($rose(pushbutton_in_n_i) && !system_reset_out_n_oe_o
        |=> !system_reset_out_n_oe_o[*8]) else $error("reset released early");
    chk_cycle_dark: assert property (state_o == 6'h20 |-> rail_en_o == '0)
        else $error("rails on during power cycle");
    cover property (state_o == 6'h20);
    cover property (up_w != '0 && state_o == 6'h02);
    cover property ($rose(system_reset_out_n_oe_o));
endmodule
bind pms_sequencer pms_sequencer_sva #(.LONG_PRESS(LONG_PRESS), .RST_TIMEOUT(RST_TIMEOUT),
    .STEP(STEP))
    pms_sequencer_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .power_hold_in_i(power_hold_in_i),
    .main_power_request_i(main_power_request_i), .pushbutton_in_n_i(pushbutton_in_n_i),
    .manual_reset_press_i(manual_reset_press_i), .backup_supply_sense_i(backup_supply_sense_i),
    .rail_en_o(rail_en_o), .rail_keepalive_o(rail_keepalive_o),
    .system_reset_out_n_oe_o(system_reset_out_n_oe_o), .state_o(state_o));

// ==== sim/pms_host_model.sv ====
`timescale 1ns/100ps
module pms_host_model (
    input wire logic clk_i,
    input wire logic want_hold_i,
    input wire logic want_req_i,
    input wire logic [7:0] lag_i,
    output logic power_hold_o,
    output logic main_power_request_o
);
    logic [7:0] cnt = 8'h0;
    initial power_hold_o = 1'b0;
    initial main_power_request_o = 1'b0;
    // levels follow the wish after lag cycles; a slow host models a late boot
    always @(negedge clk_i) begin
        if ({want_hold_i, want_req_i} == {power_hold_o, main_power_request_o}) begin
            cnt <= 8'h0;
        end else if (cnt >= lag_i) begin
            power_hold_o <= want_hold_i;
            main_power_request_o <= want_req_i;
        end else begin
            cnt <= cnt + 8'h1;
        end
    end
endmodule

// ==== sim/tb_pms_sequencer.sv ====
`timescale 1ns/100ps
module tb_pms_sequencer
    import pms_pkg::*;
;
    logic clk = 0, rst = 1, hold_w = 0, req_w = 0, pb_n = 1, mr = 0, bk = 1, ce = 1;
    logic [7:0] lag = 8'h0;
    logic hold, req, oe, pbs_oe, pbs_pin, reset_pin;
    logic [RAILS-1:0] rails;
    logic [5:0] st;
    int fails = 0, n_tests = 0;
    initial forever #12.5 clk = ~clk;
    pms_host_model pms_host_model_inst (.clk_i(clk), .want_hold_i(hold_w), .want_req_i(req_w),
        .lag_i(lag), .power_hold_o(hold), .main_power_request_o(req));
    pms_sequencer #(.LONG_PRESS(200), .RST_TIMEOUT(20), .STEP(400)) pms_sequencer_inst (
        .clk_i(clk),
        .rst_i(rst), .ce_i(ce), .power_hold_in_i(hold), .main_power_request_i(req),
        .pushbutton_in_n_i(pb_n), .manual_reset_press_i(mr), .backup_supply_sense_i(bk),
        .rail_en_o(rails), .rail_keepalive_o(), .system_reset_out_n_o(reset_pin),
        .system_reset_out_n_oe_o(oe), .pushbutton_status_n_o(pbs_pin),
        .pushbutton_status_n_oe_o(pbs_oe),
        .state_o(st));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // waits for the next rail to come up; skipped ranks make gaps long
    task automatic step(input int rail);
        logic [12:0] was;
        int k;
        was = rails;
        k = 0;
        while (rails === was && k < 30000) begin
            @(negedge clk);
            k++;
        end
        if (k == 30000) begin
            fails++;
            report_and_stop();
        end
        check("rail step", was | (13'h1 << (rail - 1)), rails);
    endtask
    task automatic t_sleep;
        int seq[5] = '{13, 6, 7, 1, 12};
        hold_w = 1;
        foreach (seq[i]) step(seq[i]);
        repeat (9000) @(negedge clk);
        check("sleep rails", SLEEP_ON_MASK, rails);
        $display("test sleep done");
    endtask
    task automatic t_wake;
        int seq[8] = '{4, 2, 3, 5, 11, 10, 8, 9};
        int k;
        lag = 8'h14;
        req_w = 1;
        foreach (seq[i]) step(seq[i]);
        for (k = 0; k < 9000 && st !== 6'h08; k++) @(negedge clk);
        if (k == 9000) begin
            fails++;
            report_and_stop();
        end
        check("run state", 13'h8, {7'h0, st});
        check("all-on rails", ALL_RAILS, rails);
        repeat (30) @(negedge clk);
        check("reset released", 13'h1, {12'h0, oe});
        $display("test wake done");
    endtask
    task automatic t_soft;
        pb_n = 0;
        mr = 1;
        repeat (6) @(negedge clk);
        check("press reset", 13'h0, {12'h0, oe});
        check("reset pin data", 13'h0, {12'h0, reset_pin});
        check("button status", 13'h0, {11'h0, pbs_pin, pbs_oe});
        repeat (50) @(negedge clk);
        pb_n = 1;
        mr = 0;
        repeat (14) @(negedge clk);
        check("reset held", 13'h0, {12'h0, oe});
        check("button idle", 13'h1, {11'h0, pbs_pin, pbs_oe});
        repeat (30) @(negedge clk);
        check("reset done", 13'h1, {12'h0, oe});
        check("rails kept", ALL_RAILS, rails);
        $display("test soft reset done");
    endtask
    task automatic t_cycle;
        lag = 8'h0;
        pb_n = 0;
        mr = 1;
        repeat (260) @(negedge clk);
        check("cycle rails", 13'h0, rails);
        {hold_w, req_w, bk} = 3'b000;
        repeat (5) @(negedge clk);
        pb_n = 1;
        mr = 0;
        repeat (20) @(negedge clk);
        check("all off", 13'h0, rails);
        $display("test power cycle done");
    endtask
    task automatic t_abort;
        pb_n = 0;
        step(13);
        repeat (100) @(negedge clk);
        pb_n = 1;
        repeat (10) @(negedge clk);
        check("aborted boot", 13'h0, rails);
        bk = 1;
        repeat (10) @(negedge clk);
        check("shutdown rails", KEEPALIVE_MASK, rails);
        // a press while the enable is low must not reach the sequencer
        ce = 0;
        pb_n = 0;
        repeat (10) @(negedge clk);
        check("frozen state", 13'h1, {7'h0, st});
        pb_n = 1;
        ce = 1;
        repeat (10) @(negedge clk);
        check("frozen rails", KEEPALIVE_MASK, rails);
        $display("test abort done");
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        t_sleep();
        t_wake();
        t_soft();
        t_cycle();
        t_abort();
        report_and_stop();
    end
endmodule
